// ### bst_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides.
// Assumes one clock; depth must be a power of two.
module bst_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 4
) (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  output logic [WIDTH-1:0] rd_data_out,
  output logic rd_valid_out,
  input wire logic rd_ready_in
);
  localparam int AW = $clog2(DEPTH);
  // The count is one bit wider than the pointers so that full and empty differ.
  localparam logic [AW:0] FULL_CNT = DEPTH[AW:0];
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic wr_go;
  logic rd_go;

  // Full and empty are taken straight from the occupancy count.
  assign wr_ready_out = (cnt_r != FULL_CNT);
  assign rd_valid_out = (cnt_r != '0);
  assign wr_go = wr_valid_in && wr_ready_out;
  assign rd_go = rd_valid_out && rd_ready_in;
  assign rd_data_out = mem_r[rp_r];

  // Storage and pointers advance on accepted transfers only.
  always_ff @(posedge sys_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      for (int i = 0; i < DEPTH; i++)
        mem_r[i] <= '0;
    end
    else
    begin
      if (wr_go)
      begin
        mem_r[wp_r] <= wr_data_in;
        wp_r <= wp_r + 1'b1;
      end
      if (rd_go)
        rp_r <= rp_r + 1'b1;
      if (wr_go && !rd_go)
        cnt_r <= cnt_r + 1'b1;
      else if (rd_go && !wr_go)
        cnt_r <= cnt_r - 1'b1;
    end
  end
endmodule // bst_fifo

// ### bst_jtag_host.sv
// Behavioural boundary-scan test controller that drives the serial test link.
// Assumes the bench calls its tasks from one process and that sys_clk_in runs.
module bst_jtag_host (
  input wire logic sys_clk_in,
  input wire logic tdo_in,
  output logic tck_out,
  output logic tms_out,
  output logic tms_oe_n_out,
  output logic tdi_out,
  output logic tdi_oe_n_out
);
  timeunit 1ns;
  timeprecision 100ps;

  // The test clock stands low between frames, as on a board that leaves the port unused.
  initial
  begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    tms_oe_n_out = 1'b0;
    tdi_out = 1'b0;
    tdi_oe_n_out = 1'b0;
  end

  // One 125 ns bit: 7 cycles low, 12 high, 6 low. The port shows the bit shifted at a
  // rise only after the following fall, so the output is taken at the end of the bit.
  task automatic bit_cyc(input logic tms, input logic tdi, output logic tdo, output logic same);
    logic hi;
    @(posedge sys_clk_in);
    tms_out <= tms;
    tdi_out <= tdi;
    repeat (7) @(posedge sys_clk_in);
    hi = tdo_in;
    tck_out <= 1'b1;
    repeat (12) @(posedge sys_clk_in);
    same = (tdo_in === hi);
    tck_out <= 1'b0;
    repeat (5) @(posedge sys_clk_in);
    tdo = tdo_in;
  endtask

  // Releasing the pins leaves the inverse of the last level, so only the enable can mean one.
  task automatic release_pins(input logic rel);
    @(posedge sys_clk_in);
    tms_oe_n_out <= rel;
    tdi_oe_n_out <= rel;
    tms_out <= ~tms_out;
    tdi_out <= ~tdi_out;
  endtask
endmodule // bst_jtag_host

// ### bst_pkg.sv
// Package for the boundary-scan test port: TAP states, instruction codes,
// register widths and identification fields.
// Assumes a single system clock domain that oversamples the test clock.
package bst_pkg;

  localparam int BST_IR_W = 3;
  localparam int BST_ID_W = 32;
  localparam int BST_BSR_W = 89;
  localparam int BST_SYNC_STAGES = 2;
  localparam int BST_FIFO_W = 1;
  localparam int BST_FIFO_D = 4;

  // Instruction codes.
  localparam logic [2:0] BST_INS_EXTEST = 3'h0;
  localparam logic [2:0] BST_INS_IDCODE = 3'h1;
  localparam logic [2:0] BST_INS_SAMPLEZ = 3'h2;
  localparam logic [2:0] BST_INS_BYP0 = 3'h3;
  localparam logic [2:0] BST_INS_SAMPLE = 3'h4;
  localparam logic [2:0] BST_INS_RSVD = 3'h5;
  localparam logic [2:0] BST_INS_BYP1 = 3'h6;
  localparam logic [2:0] BST_INS_BYP2 = 3'h7;

  // Identification register field values; all values are arbitrary.
  localparam logic [3:0] BST_ID_REV = 4'h1;
  localparam logic [9:0] BST_ID_PART = 10'h155;
  localparam logic [5:0] BST_ID_VEND = 6'h2a;
  localparam logic [10:0] BST_ID_MFR = 11'h123;
  localparam logic BST_ID_START = 1'b1;

  // Saturation limit of the mode-select ones counter.
  localparam logic [3:0] BST_TMS_ONES = 4'hf;

  typedef enum logic [3:0] {
    BST_TLR = 4'h0,
    BST_RTI = 4'h1,
    BST_SEL_DR = 4'h2,
    BST_CAP_DR = 4'h3,
    BST_SH_DR = 4'h4,
    BST_EX1_DR = 4'h5,
    BST_PA_DR = 4'h6,
    BST_EX2_DR = 4'h7,
    BST_UPD_DR = 4'h8,
    BST_SEL_IR = 4'h9,
    BST_CAP_IR = 4'ha,
    BST_SH_IR = 4'hb,
    BST_EX1_IR = 4'hc,
    BST_PA_IR = 4'hd,
    BST_EX2_IR = 4'he,
    BST_UPD_IR = 4'hf
  } bst_state_e;

  // Serial link pins, before and after synchronisation.
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } bst_link_s;

endpackage : bst_pkg

// ### bst_tap.sv
// Boundary-scan test access port: TAP controller, instruction, bypass,
// identification and 89-cell boundary registers.
// Assumes sys_clk_in is far faster than the test clock, which it samples.
module bst_tap
  import bst_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic tck_in,
  input wire logic tms_in,
  input wire logic tms_oe_n_in,
  input wire logic tdi_in,
  input wire logic tdi_oe_n_in,
  input wire logic [BST_BSR_W-1:0] pad_state_in,
  output logic tdo_out,
  output logic tdo_oe_n_out,
  output logic dq_float_out,
  output logic [BST_IR_W-1:0] ir_out,
  output logic [3:0] tap_state_out
);

  bst_link_s link_raw;
  bst_link_s sync1_r;
  bst_link_s sync2_r;
  logic tck_d_r;
  logic rise;
  logic fall;
  bst_state_e st_r;
  bst_state_e st_nxt;
  logic [BST_IR_W-1:0] ir_sh_r;
  logic [BST_IR_W-1:0] ir_r;
  logic byp_r;
  logic [BST_ID_W-1:0] id_r;
  logic [BST_BSR_W-1:0] bsr_r;
  logic tdo_bit;
  logic tdo_r;
  logic tdo_oe_n_r;
  logic fifo_ready;
  logic fifo_valid;
  logic fifo_data;
  logic fifo_push;
  logic [3:0] tms_ones_r;

  // An undriven mode-select or data input pin reads as one, as if pulled up.
  assign link_raw.tck = tck_in;
  assign link_raw.tms = tms_oe_n_in ? 1'b1 : tms_in;
  assign link_raw.tdi = tdi_oe_n_in ? 1'b1 : tdi_in;

  // Two-stage synchroniser; only the second stage is read by logic.
  always_ff @(posedge sys_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
      tck_d_r <= 1'b0;
    end
    else
    begin
      sync1_r <= link_raw;
      sync2_r <= sync1_r;
      tck_d_r <= sync2_r.tck;
    end
  end

  // Edge detection; a test clock held low yields no edges and idles the port.
  assign rise = sync2_r.tck && !tck_d_r;
  assign fall = !sync2_r.tck && tck_d_r;

  // Identification word, built from arbitrary field values.
  function automatic logic [BST_ID_W-1:0] id_word();
    id_word = {BST_ID_REV, BST_ID_PART, BST_ID_VEND, BST_ID_MFR, BST_ID_START};
  endfunction

  // Bypass codes, including the three aliases.
  function automatic logic is_bypass(input logic [BST_IR_W-1:0] c);
    is_bypass = (c == BST_INS_BYP0) || (c == BST_INS_BYP1) || (c == BST_INS_BYP2) ||
                (c == BST_INS_RSVD);
  endfunction

  // Chain selected by the boundary-scan instructions.
  function automatic logic is_chain(input logic [BST_IR_W-1:0] c);
    is_chain = (c == BST_INS_EXTEST) || (c == BST_INS_SAMPLEZ) || (c == BST_INS_SAMPLE);
  endfunction

  // Standard sixteen-state next-state map.
  always_comb
  begin
    st_nxt = st_r;
    unique case (st_r)
      BST_TLR: st_nxt = sync2_r.tms ? BST_TLR : BST_RTI;
      BST_RTI: st_nxt = sync2_r.tms ? BST_SEL_DR : BST_RTI;
      BST_SEL_DR: st_nxt = sync2_r.tms ? BST_SEL_IR : BST_CAP_DR;
      BST_CAP_DR: st_nxt = sync2_r.tms ? BST_EX1_DR : BST_SH_DR;
      BST_SH_DR: st_nxt = sync2_r.tms ? BST_EX1_DR : BST_SH_DR;
      BST_EX1_DR: st_nxt = sync2_r.tms ? BST_UPD_DR : BST_PA_DR;
      BST_PA_DR: st_nxt = sync2_r.tms ? BST_EX2_DR : BST_PA_DR;
      BST_EX2_DR: st_nxt = sync2_r.tms ? BST_UPD_DR : BST_SH_DR;
      BST_UPD_DR: st_nxt = sync2_r.tms ? BST_SEL_DR : BST_RTI;
      BST_SEL_IR: st_nxt = sync2_r.tms ? BST_TLR : BST_CAP_IR;
      BST_CAP_IR: st_nxt = sync2_r.tms ? BST_EX1_IR : BST_SH_IR;
      BST_SH_IR: st_nxt = sync2_r.tms ? BST_EX1_IR : BST_SH_IR;
      BST_EX1_IR: st_nxt = sync2_r.tms ? BST_UPD_IR : BST_PA_IR;
      BST_PA_IR: st_nxt = sync2_r.tms ? BST_EX2_IR : BST_PA_IR;
      BST_EX2_IR: st_nxt = sync2_r.tms ? BST_UPD_IR : BST_SH_IR;
      BST_UPD_IR: st_nxt = sync2_r.tms ? BST_SEL_DR : BST_RTI;
    endcase
  end

  // Power-up reset lands in test-logic-reset; no test reset pin exists.
  always_ff @(posedge sys_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      st_r <= BST_TLR;
    else if (rise)
      st_r <= st_nxt;
  end

  // Counts consecutive ones on mode-select, used only by two checks.
  always_ff @(posedge sys_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      tms_ones_r <= '0;
    else if (rise)
      tms_ones_r <= !sync2_r.tms ? 4'h0 : (tms_ones_r == BST_TMS_ONES ? tms_ones_r :
                    tms_ones_r + 4'h1);
  end

  // Instruction register: shift, then update; reset state loads IDCODE.
  always_ff @(posedge sys_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      ir_sh_r <= '0;
      ir_r <= BST_INS_IDCODE;
    end
    else if (rise)
    begin
      unique case (st_r)
        BST_TLR: ir_r <= BST_INS_IDCODE;
        BST_CAP_IR: ir_sh_r <= 3'h1;
        BST_SH_IR: ir_sh_r <= {sync2_r.tdi, ir_sh_r[BST_IR_W-1:1]};
        BST_UPD_IR: ir_r <= ir_sh_r;
        default: ir_sh_r <= ir_sh_r;
      endcase
    end
  end

  // Data registers; the chain captures pad states only, never array data.
  always_ff @(posedge sys_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      byp_r <= 1'b0;
      id_r <= '0;
      bsr_r <= '0;
    end
    else if (rise)
    begin
      if (st_r == BST_UPD_IR && is_bypass(ir_sh_r))
        byp_r <= 1'b0;
      if (st_r == BST_CAP_DR)
      begin
        if (ir_r == BST_INS_IDCODE)
          id_r <= id_word();
        if (is_chain(ir_r))
          bsr_r <= pad_state_in;
        if (is_bypass(ir_r))
          byp_r <= 1'b0;
      end
      else if (st_r == BST_SH_DR)
      begin
        if (ir_r == BST_INS_IDCODE)
          id_r <= {sync2_r.tdi, id_r[BST_ID_W-1:1]};
        if (is_chain(ir_r))
          bsr_r <= {sync2_r.tdi, bsr_r[BST_BSR_W-1:1]};
        if (is_bypass(ir_r))
          byp_r <= sync2_r.tdi;
      end
    end
  end

  // Output mux: cell 1 (pad 6N) leaves first, cell 89 last.
  always_comb
  begin
    tdo_bit = byp_r;
    if (st_r == BST_SH_IR)
      tdo_bit = ir_sh_r[0];
    else if (ir_r == BST_INS_IDCODE)
      tdo_bit = id_r[0];
    else if (is_chain(ir_r))
      tdo_bit = bsr_r[0];
  end

  // One bit enters the FIFO at every rising edge spent in a shift state.
  assign fifo_push = rise && (st_r == BST_SH_DR || st_r == BST_SH_IR);

  // Shifted bits pass a small FIFO; it drains at each falling test-clock edge.
  bst_fifo #(
    .WIDTH(BST_FIFO_W),
    .DEPTH(BST_FIFO_D)
  ) u_fifo (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .wr_data_in(tdo_bit),
    .wr_valid_in(fifo_push),
    .wr_ready_out(fifo_ready),
    .rd_data_out(fifo_data),
    .rd_valid_out(fifo_valid),
    .rd_ready_in(fall)
  );

  // Output driven only after a falling edge, enable low while shifting.
  always_ff @(posedge sys_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      tdo_r <= 1'b0;
      tdo_oe_n_r <= 1'b1;
    end
    else if (fall)
    begin
      tdo_r <= fifo_valid ? fifo_data : tdo_r;
      tdo_oe_n_r <= !fifo_valid;
    end
  end

  assign tdo_out = tdo_r;
  assign tdo_oe_n_out = tdo_oe_n_r;
  // Data pins float only for EXTEST and SAMPLE-Z; reset restores normal use.
  assign dq_float_out = (ir_r == BST_INS_EXTEST) || (ir_r == BST_INS_SAMPLEZ);
  assign ir_out = ir_r;
  assign tap_state_out = st_r;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);

  sequence s_five_ones;
    rise && sync2_r.tms ##1 (tms_ones_r >= 4'h5);
  endsequence

  a_five_ones_reset: assert property (tms_ones_r >= 4'h5 |-> st_r == BST_TLR)
    else $error("Five ones on mode-select did not reach reset state.");
  a_reset_loads_id: assert property (st_r == BST_TLR && rise |=> ir_r == BST_INS_IDCODE)
    else $error("Reset state did not load IDCODE.");
  a_float_extest: assert property (ir_r == BST_INS_EXTEST |-> dq_float_out)
    else $error("EXTEST did not float data pins.");
  a_float_samplez: assert property (ir_r == BST_INS_SAMPLEZ |-> dq_float_out)
    else $error("SAMPLE-Z did not float data pins.");
  a_sample_drives: assert property (ir_r == BST_INS_SAMPLE |-> !dq_float_out)
    else $error("SAMPLE floated data pins.");
  a_idcode_shift: assert property (rise && st_r == BST_SH_DR && ir_r == BST_INS_IDCODE
                                   |=> id_r[BST_ID_W-1] == $past(sync2_r.tdi))
    else $error("Serial input did not enter ID register first stage.");
  a_bypass_hold: assert property (rise && st_r == BST_SH_DR && is_bypass(ir_r)
                                  |=> byp_r == $past(sync2_r.tdi))
    else $error("Bypass register did not hold shifted bit.");
  a_bypass_clear: assert property (rise && st_r == BST_CAP_DR && is_bypass(ir_r)
                                   |=> !byp_r)
    else $error("Bypass register not cleared on capture.");
  a_tdo_on_fall: assert property (!fall |=> $stable(tdo_r))
    else $error("Test data output changed outside a falling edge.");
  a_capture_pads: assert property (rise && st_r == BST_CAP_DR && is_chain(ir_r)
                                   |=> bsr_r == $past(pad_state_in))
    else $error("Chain did not capture pad states.");
  a_state_on_rise: assert property (!rise |=> $stable(st_r))
    else $error("TAP state moved without a rising edge.");

  // A full FIFO would silently drop a shifted bit, so overflow is checked here.
  a_fifo_room: assert property (fifo_push |-> fifo_ready)
    else $error("Shift bit offered to a full output FIFO.");
  a_five_ones_walk: assert property (s_five_ones |-> st_r == BST_TLR)
    else $error("Run of ones on mode-select left the port outside reset state.");
  a_bypass_select: assert property (
    rise && st_r == BST_UPD_IR && is_bypass(ir_sh_r) |=> !byp_r)
    else $error("Bypass register not cleared when bypass was selected.");
  a_ir_capture: assert property (rise && st_r == BST_CAP_IR |=> ir_sh_r == 3'h1)
    else $error("Instruction register did not capture its fixed pattern.");
  a_chain_shift: assert property (
    rise && st_r == BST_SH_DR && is_chain(ir_r) |=> bsr_r[BST_BSR_W-1] == $past(sync2_r.tdi))
    else $error("Serial input did not enter the last chain cell.");
  a_tdo_release: assert property (fall && !fifo_valid |=> tdo_oe_n_r)
    else $error("Test data output still enabled with no bit pending.");

endmodule // bst_tap

// ### tb_boundary_scan_tap.sv
// Self-checking bench for the boundary-scan test port.
// Assumes the controller model above drives the link and the bench drives the pads.
module tb_boundary_scan_tap
  import bst_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [88:0] PADS = 89'h1_a5c3_f00f_9669_e1d2_b478_5a;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic tck, tms, tms_oe_n, tdi, tdi_oe_n, tdo, tdo_oe_n, dq_float;
  logic [88:0] pads = PADS;
  logic [2:0] ir;
  logic [3:0] st;
  int n_errors = 0;
  int check_count = 0;
  logic [2:0] codes [6] = '{3'h0, 3'h2, 3'h4, 3'h3, 3'h6, 3'h7};

  // Free-running system clock at 200 MHz.
  always #2.5 sys_clk = ~sys_clk;

  bst_jtag_host host (.sys_clk_in(sys_clk), .tdo_in(tdo), .tck_out(tck), .tms_out(tms),
    .tms_oe_n_out(tms_oe_n), .tdi_out(tdi), .tdi_oe_n_out(tdi_oe_n));

  bst_tap uut (.sys_clk_in(sys_clk), .sys_rst_in(sys_rst), .tck_in(tck), .tms_in(tms),
    .tms_oe_n_in(tms_oe_n), .tdi_in(tdi), .tdi_oe_n_in(tdi_oe_n), .pad_state_in(pads),
    .tdo_out(tdo), .tdo_oe_n_out(tdo_oe_n), .dq_float_out(dq_float), .ir_out(ir),
    .tap_state_out(st));

  // One compare for every kind of value, widened so that unknown bits never match.
  task automatic chk(input string name, input logic [127:0] exp, input logic [127:0] got);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Full scan from Run-Test/Idle back to Run-Test/Idle; the bit shift is LSB first.
  task automatic scan(input logic is_ir, input int n, input logic [127:0] din,
    output logic [127:0] dout);
    logic t, s;
    dout = '0;
    host.bit_cyc(1'b1, 1'b0, t, s);
    if (is_ir)
      host.bit_cyc(1'b1, 1'b0, t, s);
    host.bit_cyc(1'b0, 1'b0, t, s);
    host.bit_cyc(1'b0, 1'b0, t, s);
    for (int i = 0; i < n; i++)
    begin
      host.bit_cyc(i == n - 1, din[i], t, s);
      dout[i] = t;
      chk("tdo_hold", 1'b1, s);
      if (i < n - 1)
        chk("tdo_oe_n", 1'b0, tdo_oe_n);
    end
    host.bit_cyc(1'b1, 1'b0, t, s);
    host.bit_cyc(1'b0, 1'b0, t, s);
  endtask

  // After reset the port idles in Test-Logic-Reset with the identification code loaded.
  task automatic test_reset();
    chk("state", BST_TLR, st);
    chk("ir", BST_INS_IDCODE, ir);
    chk("dq_float", 1'b0, dq_float);
    chk("tdo_oe_n", 1'b1, tdo_oe_n);
  endtask

  // Forty shifts show the whole code and then the first eight serial inputs.
  task automatic test_idcode();
    logic [127:0] d;
    logic t, s;
    host.bit_cyc(1'b0, 1'b0, t, s);
    scan(1'b0, 40, {32'h0, 8'h96}, d);
    chk("idcode", {8'h96, BST_ID_REV, BST_ID_PART, BST_ID_VEND, BST_ID_MFR, 1'b1}, d);
  endtask

  // Every usable code except IDCODE is loaded in turn; the reserved one is never sent.
  task automatic test_instr();
    logic [127:0] d;
    foreach (codes[k])
    begin
      scan(1'b1, 3, codes[k], d);
      chk("ir_capture", 3'h1, d);
      chk("ir", codes[k], ir);
      chk("dq_float", codes[k] == 3'h0 || codes[k] == 3'h2, dq_float);
      if (codes[k] == 3'h3 || codes[k] >= 3'h6)
      begin
        scan(1'b0, 8, 8'hb5, d);
        chk("bypass", 8'h6a, d);
      end
      else
      begin
        // Shifting in the inverse shows that each capture really reloads the pads.
        scan(1'b0, 89, ~PADS, d);
        chk("chain", PADS, d);
      end
    end
  endtask

  // Undriven control pins count as ones, so five bits walk the port back to reset.
  task automatic test_float();
    logic [127:0] d;
    logic t, s;
    scan(1'b1, 3, BST_INS_EXTEST, d);
    chk("dq_float", 1'b1, dq_float);
    host.release_pins(1'b1);
    repeat (5) host.bit_cyc(1'b0, 1'b0, t, s);
    chk("state", BST_TLR, st);
    chk("ir", BST_INS_IDCODE, ir);
    chk("dq_float", 1'b0, dq_float);
    host.release_pins(1'b0);
  endtask

  // Main sequence: 12 cycles of reset, then the scenarios.
  initial
  begin
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    test_reset();
    test_idcode();
    test_instr();
    test_float();
    stop_test();
  end

  // Watchdog well beyond the roughly 55 us that the scans take.
  initial
  begin
    #400us;
    n_errors++;
    $display("MISMATCH watchdog expected done seen hang");
    stop_test();
  end
endmodule // tb_boundary_scan_tap
